// [design/mvx_pkg.sv]
// shared constants, layouts and carriers for the measured value exporter
package mvx_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_115200 = 115200;
  localparam logic [11:0] DIV_9600 = 12'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [11:0] DIV_19200 =
    12'((CLK_HZ + BAUD_19200 / 2) / BAUD_19200);
  localparam logic [11:0] DIV_38400 =
    12'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);
  localparam logic [11:0] DIV_115200 =
    12'((CLK_HZ + BAUD_115200 / 2) / BAUD_115200);
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [1:0] BAUD_SEL_9600 = 2'h0;
  localparam logic [1:0] BAUD_SEL_19200 = 2'h1;
  localparam logic [1:0] BAUD_SEL_38400 = 2'h2;
  localparam logic [1:0] IF_RS232 = 2'h0;
  localparam logic [1:0] IF_USB = 2'h1;
  localparam logic [1:0] IF_GPIB = 2'h2;
  localparam logic [1:0] IF_PRINT = 2'h3;
  localparam logic [1:0] SCAN_OFF = 2'h0;
  localparam logic [4:0] CODE_REL = 5'h10;
  localparam logic [4:0] CODE_TEMP = 5'h11;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [3:0] UART_BITS = 4'h9;
  localparam int MANT_MAX = 8;

  // measurement as handed over at end of conversion; digits[MANT_MAX-1] is the msd
  typedef struct packed {
    logic fault;
    logic ovr;
    logic neg;
    logic [4:0] code;
    logic [3:0] disp;
    logic [MANT_MAX-1:0][3:0] digits;
  } mvx_meas_s;

  typedef struct packed {
    logic [1:0] scan;
    logic mux_sel;
    logic trig_int;
    logic [1:0] iface;
    logic [1:0] baud;
    logic export_en;
  } mvx_ctrl_s;

  typedef struct packed {
    logic [2:0] int_d;
    logic [2:0] frac_d;
    logic [2:0] ofrac_d;
    logic exp_neg;
    logic [4:0] exp;
    logic [4:0] oexp;
    logic [4:0] fexp;
  } mvx_lay_s;

  typedef enum logic [1:0] {
    MVX_IDLE,
    MVX_EMIT
  } mvx_fmt_e;
endpackage

// [design/mvx_exporter.sv]
// ascii record framer, its character fifo and serial transmitter
`timescale 1ns/1ns
`default_nettype none
module mvx_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = cnt_q != (AW + 1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? AW'((wr_q + 1'b1) % DEPTH) : wr_q;
    rd_d = pop ? AW'((rd_q + 1'b1) % DEPTH) : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  a_fifo_bound: assert property (@(posedge sys_clk) disable iff (srst)
    cnt_q <= (AW + 1)'(DEPTH)) else $error("fifo count past depth");
endmodule

module mvx_exporter
  import mvx_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic meas_done,
  input wire mvx_meas_s meas_in,
  input wire logic trig_in,
  input wire logic enter_key,
  output logic txd
);
  mvx_ctrl_s ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] rec_cnt_q, rec_cnt_d;
  mvx_meas_s held_q, held_d;
  logic req_q, req_d;
  mvx_fmt_e st_q, st_d;
  logic [4:0] pos_q, pos_d;
  mvx_lay_s lay;
  logic [4:0] last_pos;
  logic [7:0] ch;
  logic allowed, event_in, push_ok, f_ready, f_valid, tx_take;
  logic [7:0] f_data;
  logic [$clog2(FIFO_DEPTH):0] f_level;
  logic [11:0] bdiv_q, bdiv_d, div_sel;
  logic [3:0] bit_q, bit_d;
  logic [9:0] sh_q, sh_d;
  logic busy_q, busy_d;

  // fixed per-range patterns; relative and temperature share +00 exponent
  function automatic mvx_lay_s layout(input logic [4:0] code);
    mvx_lay_s l;
    logic [1:0] dec;
    l = '0;
    dec = 2'(code % 5'h3);
    l.int_d = 3'(dec) + 3'h2;
    l.frac_d = 3'h7 - l.int_d;
    l.ofrac_d = l.frac_d;
    l.oexp = 5'h13 - 5'(dec);
    l.fexp = dec == 2'h0 ? 5'h1d : (dec == 2'h1 ? 5'h1c : 5'h1b);
    l.exp_neg = code < 5'h3 || code == 5'hc;
    l.exp = code < 5'hc ? 5'h3 * (5'(code / 5'h3) - 5'h1) : 5'h3;
    if (code < 5'h3) begin
      l.exp = 5'h3;
    end
    if (code == 5'h0) begin
      l.fexp = 5'h1c;
    end
    if (code == 5'hb) begin
      l.fexp = 5'h1c;
    end
    if (code == 5'h9) begin
      l.frac_d = 3'h4;
    end
    if (code >= 5'hc && code < CODE_REL) begin
      dec = 2'(code - 5'hc);
      l.int_d = dec == 2'h0 ? 3'h4 : 3'(dec) + 3'h1;
      l.frac_d = 3'h6 - l.int_d;
      l.ofrac_d = l.frac_d;
      l.oexp = 5'h15 - 5'(l.int_d);
      l.fexp = 5'h1f - 5'(l.int_d);
      l.exp = dec == 2'h0 ? 5'h3 : 5'h0;
    end
    if (code == CODE_REL || code == CODE_TEMP) begin
      l.int_d = 3'h3;
      l.frac_d = code == CODE_TEMP ? 3'h1 : 3'h3;
      l.ofrac_d = l.frac_d;
      l.exp_neg = 1'b0;
      l.exp = 5'h0;
      l.oexp = 5'h12;
      l.fexp = 5'h1c;
    end
    return l;
  endfunction

  function automatic logic [7:0] dec_ch(input logic [4:0] v, input logic hi);
    logic [4:0] t;
    t = v >= 5'h14 ? 5'h2 : (v >= 5'ha ? 5'h1 : 5'h0);
    return hi ? CH_ZERO + 8'(t) : CH_ZERO + 8'(v - 5'ha * t);
  endfunction

  assign lay = layout(held_q.code);
  assign allowed = ctrl_q.export_en && ctrl_q.iface != IF_GPIB
    && !(ctrl_q.mux_sel && ctrl_q.scan != SCAN_OFF);
  assign event_in = ctrl_q.trig_int ? (trig_in || enter_key)
    : meas_done;

  // character at each record position; field spacing is set by range, but code 9 gets one more fraction digit on over-range or fault
  always_comb begin
    logic [2:0] nf;
    logic [4:0] k, e;
    logic sent;
    nf = 3'h0;
    k = 5'h0;
    e = 5'h0;
    sent = held_q.fault || held_q.ovr;
    nf = sent ? lay.ofrac_d : lay.frac_d;
    e = held_q.fault ? lay.fexp : (held_q.ovr ? lay.oexp : lay.exp);
    last_pos = 5'(lay.int_d) + 5'(nf) + 5'h7;
    k = pos_q <= 5'(lay.int_d) ? pos_q - 5'h1 : pos_q - 5'h2;
    ch = CH_ZERO;
    if (pos_q == 5'h0) begin
      ch = (held_q.neg && !held_q.fault) ? CH_MINUS : CH_SPACE;
    end else if (pos_q == 5'(lay.int_d) + 5'h1) begin
      ch = CH_DOT;
    end else if (pos_q <= 5'(lay.int_d) + 5'(nf) + 5'h1) begin
      if (sent) begin
        ch = k == 5'h0 ? CH_ONE : CH_ZERO;
      end else if (k >= 5'(held_q.disp)) begin
        ch = CH_ZERO;
      end else begin
        ch = CH_ZERO + 8'(held_q.digits[MANT_MAX - 1 - int'(k)]);
      end
    end else if (pos_q == last_pos - 5'h5) begin
      ch = CH_E;
    end else if (pos_q == last_pos - 5'h4) begin
      ch = (lay.exp_neg && !sent) ? CH_MINUS : CH_PLUS;
    end else if (pos_q == last_pos - 5'h3) begin
      ch = dec_ch(e, 1'b1);
    end else if (pos_q == last_pos - 5'h2) begin
      ch = dec_ch(e, 1'b0);
    end else if (pos_q == last_pos - 5'h1) begin
      ch = CH_CR;
    end else begin
      ch = CH_LF;
    end
  end

  assign push_ok = st_q == MVX_EMIT && f_ready;

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = '0;
    held_d = meas_done ? meas_in : held_q;
    req_d = req_q;
    st_d = st_q;
    pos_d = pos_q;
    rec_cnt_d = rec_cnt_q;
    if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_d = mvx_ctrl_s'(reg_wdata[$bits(mvx_ctrl_s)-1:0]);
    end
    if (reg_rd && reg_addr == ADDR_CTRL) begin
      rdata_d = 32'(ctrl_q);
    end else if (reg_rd && reg_addr == ADDR_STATUS) begin
      rdata_d = {rec_cnt_q, 8'(f_level), 6'h0, busy_q, st_q == MVX_EMIT};
    end
    case (st_q)
      MVX_IDLE: begin
        // a request left over from before a refusal must not start a record
        if (req_q && allowed) begin
          st_d = MVX_EMIT;
          pos_d = 5'h0;
          req_d = 1'b0;
          held_d = held_q;
        end
      end
      MVX_EMIT: begin
        held_d = held_q;
        if (push_ok) begin
          pos_d = pos_q + 5'h1;
          if (pos_q == last_pos) begin
            st_d = MVX_IDLE;
            rec_cnt_d = rec_cnt_q + 16'h1;
          end
        end
      end
      default: st_d = MVX_IDLE;
    endcase
    // a new event beside the accept is kept for the next record
    if (event_in && allowed) begin
      req_d = 1'b1;
    end
    if (!allowed) begin
      req_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q <= '0;
      rdata_q <= '0;
      held_q <= '0;
      req_q <= 1'b0;
      st_q <= MVX_IDLE;
      pos_q <= '0;
      rec_cnt_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      held_q <= held_d;
      req_q <= req_d;
      st_q <= st_d;
      pos_q <= pos_d;
      rec_cnt_q <= rec_cnt_d;
    end
  end
  assign reg_rdata = rdata_q;

  mvx_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(st_q == MVX_EMIT),
    .in_ready(f_ready),
    .in_data(ch),
    .out_valid(f_valid),
    .out_ready(tx_take),
    .out_data(f_data),
    .level(f_level)
  );

  // the framer stalls on a full fifo, so the line rate paces it
  always_comb begin
    case (ctrl_q.baud)
      BAUD_SEL_9600: div_sel = DIV_9600;
      BAUD_SEL_19200: div_sel = DIV_19200;
      BAUD_SEL_38400: div_sel = DIV_38400;
      default: div_sel = DIV_115200;
    endcase
  end

  assign tx_take = !busy_q && f_valid;

  always_comb begin
    busy_d = busy_q;
    bdiv_d = bdiv_q;
    bit_d = bit_q;
    sh_d = sh_q;
    if (tx_take) begin
      busy_d = 1'b1;
      sh_d = {1'b1, f_data, 1'b0};
      bdiv_d = div_sel - 12'h1;
      bit_d = UART_BITS;
    end else if (busy_q) begin
      if (bdiv_q == 12'h0) begin
        bdiv_d = div_sel - 12'h1;
        sh_d = {1'b1, sh_q[9:1]};
        if (bit_q == 4'h0) begin
          busy_d = 1'b0;
        end else begin
          bit_d = bit_q - 4'h1;
        end
      end else begin
        bdiv_d = bdiv_q - 12'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      bdiv_q <= '0;
      bit_q <= '0;
      sh_q <= 10'h3ff;
    end else begin
      busy_q <= busy_d;
      bdiv_q <= bdiv_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
    end
  end
  assign txd = sh_q[0];

  a_reset_disabled: assert property (@(posedge sys_clk)
    srst |=> !ctrl_q.export_en) else $error("export on after reset");
  a_gpib_blocks: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl_q.iface == IF_GPIB && st_q == MVX_IDLE |=> st_q == MVX_IDLE)
    else $error("record started on gpib");
  a_scan_blocks: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl_q.mux_sel && ctrl_q.scan != SCAN_OFF |=> !req_q)
    else $error("request held during scan");
  a_event_request: assert property (@(posedge sys_clk) disable iff (srst)
    event_in && allowed && $past(allowed) |=> req_q || st_q == MVX_EMIT)
    else $error("event lost");
  a_pos_space: assert property (@(posedge sys_clk) disable iff (srst)
    push_ok && pos_q == 5'h0 && !held_q.neg |-> ch == CH_SPACE)
    else $error("positive sign not space");
  a_sent_lead: assert property (@(posedge sys_clk) disable iff (srst)
    push_ok && pos_q == 5'h1 && (held_q.ovr || held_q.fault) |-> ch == CH_ONE)
    else $error("sentinel lead digit wrong");
  a_fault_sign: assert property (@(posedge sys_clk) disable iff (srst)
    push_ok && pos_q == 5'h0 && held_q.fault |-> ch == CH_SPACE)
    else $error("fault sentinel not positive");
  a_record_end: assert property (@(posedge sys_clk) disable iff (srst)
    push_ok && pos_q == last_pos |-> ch == CH_LF ##1 st_q == MVX_IDLE)
    else $error("record not ended by lf");
  a_start_bit: assert property (@(posedge sys_clk) disable iff (srst)
    tx_take |=> !txd && busy_q) else $error("no start bit");
  a_temp_dot: assert property (@(posedge sys_clk) disable iff (srst)
    push_ok && held_q.code == CODE_TEMP && pos_q == 5'h4 |-> ch == CH_DOT)
    else $error("temperature point misplaced");
endmodule
`default_nettype wire

// [verification/mvx_uart_rx.sv]
// serial receiving computer: 8n1 receiver that hands each character over
`timescale 1ns/1ns
`default_nettype none
module mvx_uart_rx #(
  parameter int DIV = 174
) (
  input wire logic sys_clk,
  input wire logic txd,
  output logic [7:0] rx_byte,
  output logic rx_stb,
  output logic frame_err
);
  // listen only: nothing is ever sent back while export runs
  initial begin
    rx_byte = 8'h00;
    rx_stb = 1'b0;
    frame_err = 1'b0;
    forever begin
      @(negedge txd);
      // sample mid-bit so edge jitter of the sender does not matter
      repeat (DIV / 2) @(posedge sys_clk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (DIV) @(posedge sys_clk);
          rx_byte[i] = txd;
        end
        repeat (DIV) @(posedge sys_clk);
        if (txd !== 1'b1) frame_err = 1'b1;
        #1 rx_stb = 1'b1;
        @(posedge sys_clk);
        #1 rx_stb = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/mvx_exporter_tb.sv]
// self-checking bench for the measured value exporter
`timescale 1ns/1ns
`default_nettype none
module mvx_exporter_tb;
  import mvx_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic meas_done = 1'b0;
  mvx_meas_s meas_in = '0;
  logic trig_in = 1'b0;
  logic enter_key = 1'b0;
  logic txd;
  logic [7:0] rx_byte;
  logic rx_stb;
  logic frame_err;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] rx_q[$];
  logic [7:0] exp_q[$];
  logic [31:0] rv;
  mvx_meas_s m;

  always #25 sys_clk = ~sys_clk;

  mvx_exporter #(.FIFO_DEPTH(8)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .meas_done(meas_done), .meas_in(meas_in),
    .trig_in(trig_in), .enter_key(enter_key), .txd(txd)
  );

  mvx_uart_rx #(.DIV(int'(DIV_115200))) i_rx (
    .sys_clk(sys_clk), .txd(txd), .rx_byte(rx_byte), .rx_stb(rx_stb),
    .frame_err(frame_err)
  );

  always @(posedge sys_clk) begin
    if (rx_stb === 1'b1) rx_q.push_back(rx_byte);
    cyc <= cyc + 1;
    if (cyc == 99500) begin
      fails++;
      $display("[FAIL] run time limit reached");
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp(string what, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic pulse_meas(mvx_meas_s v);
    @(posedge sys_clk);
    meas_in <= v;
    meas_done <= 1'b1;
    @(posedge sys_clk);
    meas_done <= 1'b0;
  endtask

  // txd must stay idle: a refused event may not start a frame
  task automatic silent(string what);
    logic bad;
    bad = 1'b0;
    repeat (100) begin
      @(posedge sys_clk);
      if (txd !== 1'b1) bad = 1'b1;
    end
    cmp(what, 32'h1, {31'h0, ~bad});
  endtask

  // builds the expected record from the range layout table
  function automatic void build(mvx_meas_s v);
    int ni;
    int nf;
    string e;
    ni = 2;
    nf = 5;
    e = v.fault ? "+28" : v.ovr ? "+19" : "-03";
    if (v.code == 5'd12) begin
      ni = 4;
      nf = 2;
      e = v.fault ? "+27" : v.ovr ? "+17" : "-03";
    end else if (v.code == CODE_TEMP) begin
      ni = 3;
      nf = 1;
      e = v.fault ? "+28" : v.ovr ? "+18" : "+00";
    end
    exp_q.delete();
    exp_q.push_back((v.neg && !v.fault) ? CH_MINUS : CH_SPACE);
    for (int k = 0; k < ni + nf; k++) begin
      if (k == ni) exp_q.push_back(CH_DOT);
      if (v.fault || v.ovr) exp_q.push_back(k == 0 ? CH_ONE : CH_ZERO);
      else if (k < int'(v.disp))
        exp_q.push_back(CH_ZERO + {4'h0, v.digits[MANT_MAX-1-k]});
      else exp_q.push_back(CH_ZERO);
    end
    exp_q.push_back(CH_E);
    for (int i = 0; i < 3; i++) exp_q.push_back(8'(e[i]));
    exp_q.push_back(CH_CR);
    exp_q.push_back(CH_LF);
  endfunction

  task automatic check_rec(string what);
    int n;
    n = 0;
    while (rx_q.size() < exp_q.size() && n < 2000 * exp_q.size()) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({what, " length"}, exp_q.size(), rx_q.size());
    cmp({what, " width"}, 32'h1, {31'h0, rx_q.size() <= 48});
    foreach (exp_q[i])
      if (i < rx_q.size()) cmp(what, {24'h0, exp_q[i]}, {24'h0, rx_q[i]});
    rx_q.delete();
    repeat (100) @(posedge sys_clk);
  endtask

  // enter key starts a frame; a reset in mid-frame must idle the line
  task automatic enter_then_reset();
    int n;
    n = 0;
    @(posedge sys_clk);
    enter_key <= 1'b1;
    @(posedge sys_clk);
    enter_key <= 1'b0;
    while (txd !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    cmp("enter key start bit", 32'h0, {31'h0, txd});
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(ADDR_CTRL);
    cmp("ctrl after mid reset", 32'h0, rv);
    cmp("line idle after reset", 32'h1, {31'h0, txd});
  endtask

  function automatic mvx_meas_s rnd(logic [4:0] c, logic [3:0] d);
    mvx_meas_s v;
    v = '0;
    v.code = c;
    v.disp = d;
    v.neg = 1'($urandom);
    for (int k = 0; k < MANT_MAX; k++) v.digits[k] = 4'($urandom % 10);
    return v;
  endfunction

  initial begin
    void'($urandom(32'h08e03838));
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    rd(ADDR_CTRL);
    cmp("ctrl reset", 32'h0, rv);
    rd(8'h08);
    cmp("unmapped read", 32'h0, rv);
    pulse_meas(rnd(5'd0, 4'd7));
    silent("idle after reset");
    wr(ADDR_CTRL, 32'h17);
    pulse_meas(rnd(5'd0, 4'd7));
    silent("parallel bus iface");
    wr(ADDR_CTRL, 32'hc7);
    pulse_meas(rnd(5'd0, 4'd7));
    silent("mux scanning");
    wr(ADDR_CTRL, 32'h07);
    m = rnd(5'd0, 4'd4);
    m.neg = 1'b0;
    build(m);
    pulse_meas(m);
    check_rec("short display record");
    m = rnd(5'd0, 4'd7);
    m.ovr = 1'b1;
    m.neg = 1'b1;
    build(m);
    pulse_meas(m);
    check_rec("over range record");
    m = rnd(5'd12, 4'd6);
    m.fault = 1'b1;
    build(m);
    pulse_meas(m);
    check_rec("fault record");
    wr(ADDR_CTRL, 32'h27);
    m = rnd(CODE_TEMP, 4'd4);
    build(m);
    pulse_meas(m);
    silent("meas under internal trigger");
    @(posedge sys_clk);
    trig_in <= 1'b1;
    @(posedge sys_clk);
    trig_in <= 1'b0;
    check_rec("temperature record");
    cmp("stop bits", 32'h0, {31'h0, frame_err});
    rd(ADDR_STATUS);
    cmp("status after records", 32'h0004_0000, rv);
    enter_then_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
